// *** rtl/bbx_defs.vh ***
// Constants for the bit, branch and system control execution unit.
`ifndef BBX_DEFS_VH
`define BBX_DEFS_VH

`define BBX_INSTR_BYTES    24'h000002
`define BBX_ADDR_W         24
`define BBX_RET_DEPTH      8

`define BBX_OPF_HI         15
`define BBX_OPF_LO         12
`define BBX_SUB_HI         11
`define BBX_SUB_LO         8
`define BBX_SEL_EXR        7
`define BBX_BITNO_HI       6
`define BBX_BITNO_LO       4
`define BBX_MODE_HI        3
`define BBX_MODE_LO        0
`define BBX_WORD_FORM      8

`define BBX_OP_NOP         4'h0
`define BBX_OP_BITOP       4'h1
`define BBX_OP_BCC         4'h2
`define BBX_OP_JMP         4'h3
`define BBX_OP_BSR         4'h4
`define BBX_OP_JSR         4'h5
`define BBX_OP_RTS         4'h6
`define BBX_OP_TRAP        4'h7
`define BBX_OP_RTE         4'h8
`define BBX_OP_SLEEP       4'h9
`define BBX_OP_LDC         4'hA
`define BBX_OP_STC         4'hB
`define BBX_OP_LOGC        4'hC
`define BBX_OP_MOVE        4'hD

`define BBX_BIT_XOR        4'h0
`define BBX_BIT_IXOR       4'h1
`define BBX_BIT_LD         4'h2
`define BBX_BIT_ILD        4'h3
`define BBX_BIT_ST         4'h4
`define BBX_BIT_IST        4'h5

`define BBX_LOG_AND        4'h0
`define BBX_LOG_OR         4'h1
`define BBX_LOG_XOR        4'h2

`define BBX_SRC_IMM        4'h0
`define BBX_SRC_REG        4'h1
`define BBX_SRC_MEM        4'h2

`define BBX_CC_T           4'h0
`define BBX_CC_F           4'h1
`define BBX_CC_HI          4'h2
`define BBX_CC_LS          4'h3
`define BBX_CC_CC          4'h4
`define BBX_CC_CS          4'h5
`define BBX_CC_NE          4'h6
`define BBX_CC_EQ          4'h7
`define BBX_CC_VC          4'h8
`define BBX_CC_VS          4'h9
`define BBX_CC_PL          4'hA
`define BBX_CC_MI          4'hB
`define BBX_CC_GE          4'hC
`define BBX_CC_LT          4'hD
`define BBX_CC_GT          4'hE
`define BBX_CC_LE          4'hF

`define BBX_FLAG_C         0
`define BBX_FLAG_V         1
`define BBX_FLAG_Z         2
`define BBX_FLAG_N         3
`define BBX_FLAG_I         7

`define BBX_CCR_RST        8'h80
`define BBX_EXR_RST        8'h07
`define BBX_TRAP_VEC_BASE  24'h000020

`endif

// *** rtl/bbx_exec.v ***
// Execution unit for bit, branch, call, system control and block move instructions.
// Notes on behaviour
// - Carry xor bit: carry becomes carry xor chosen operand bit.
// - Inverted carry xor: carry becomes carry xor complement of chosen bit.
// - Inverted bit forms take the bit number only from the 3-bit immediate.
// - Bit load copies the chosen operand bit into carry.
// - Inverted bit load puts the complemented chosen bit into carry.
// - Bit store writes carry into the chosen bit, other bits kept.
// - Inverted bit store writes complemented carry into the chosen bit.
// - Higher branches when C and Z are both 0; lower-or-same when either is 1.
// - Single-flag conditions test C, Z, V or N; always and never forms.
// - Signed conditions use N xor V, greater-than and less-equal add Z.
// - Jump goes unconditionally to its operand target.
// - Relative and absolute calls branch and save a return point.
// - Return resumes at the point saved by the latest call.
// - Trap enters exception handling; exception return resumes the interrupted flow.
// - Sleep moves the processor into a power-down state.
// - Control register memory transfers are words with the value in the upper byte.
// - Control load fills condition or extended register; control store copies it out.
// - Immediate AND, OR, XOR update condition or extended register.
// - No-operation only advances the program counter by 2.
// - Block move copies bytes with post-increment until count is 0; zero skips.
// - After a block move the next instruction starts at once.
// - Instructions are built from 2-byte units with op, register, extension, condition.
// - The first four bits hold the op field; condition field selects branch test.
`timescale 1ns/1ps
`include "bbx_defs.vh"

module bbx_exec #(
	parameter RET_DEPTH = `BBX_RET_DEPTH
) (
	input  wire        clk,
	input  wire        nrst,
	input  wire        issue_valid,
	output wire        issue_ready,
	input  wire [15:0] instr_word,
	input  wire [31:0] ext_word,
	input  wire [23:0] instr_len,
	input  wire [7:0]  operand_byte,
	input  wire [23:0] block_source_pointer,
	input  wire [23:0] block_dest_pointer,
	input  wire [15:0] block_count_word_reg,
	input  wire        wake_pin,
	output reg  [23:0] pc_q,
	output reg  [7:0]  condition_code_reg_q,
	output reg  [7:0]  extended_control_reg_q,
	output reg  [7:0]  result_byte_q,
	output reg         result_we_q,
	output reg  [23:0] blk_src_q,
	output reg  [23:0] blk_dst_q,
	output reg  [15:0] blk_cnt_q,
	output reg         blk_done_q,
	output reg         sleeping_q,
	output wire        mem_req,
	output reg         mem_we_q,
	output reg         mem_word_q,
	output reg  [23:0] mem_addr_q,
	output reg  [15:0] mem_wdata_q,
	input  wire        mem_ack,
	input  wire [15:0] mem_rdata
);

	localparam [2:0] ST_IDLE   = 3'h0;
	localparam [2:0] ST_MV_RD  = 3'h1;
	localparam [2:0] ST_MV_WR  = 3'h2;
	localparam [2:0] ST_LDC_RD = 3'h3;
	localparam [2:0] ST_STC_WR = 3'h4;
	localparam [2:0] ST_SLEEP  = 3'h5;
	localparam       RP_W      = (RET_DEPTH > 1) ? $clog2(RET_DEPTH) : 1;

	reg [2:0]      state_q;
	reg [23:0]     ret_stack [0:RET_DEPTH-1];
	reg [RP_W-1:0] ret_ptr_q;
	reg [23:0]     exc_pc_q;
	reg [7:0]      exc_ccr_q;
	reg [23:0]     next_pc_q;
	reg            ldc_exr_q;
	reg [7:0]      move_byte_q;
	reg            wake_s1_q;
	reg            wake_s2_q;
	reg            wake_s3_q;

	// Flag test for the condition field; the flags themselves are never written here.
	function cond_true;
		input [3:0] cc;
		input [7:0] f;
		reg c;
		reg v;
		reg z;
		reg n;
		begin
			c = f[`BBX_FLAG_C];
			v = f[`BBX_FLAG_V];
			z = f[`BBX_FLAG_Z];
			n = f[`BBX_FLAG_N];
			case (cc)
				`BBX_CC_T:  cond_true = 1'b1;
				`BBX_CC_F:  cond_true = 1'b0;
				`BBX_CC_HI: cond_true = ~(c | z);
				`BBX_CC_LS: cond_true = c | z;
				`BBX_CC_CC: cond_true = ~c;
				`BBX_CC_CS: cond_true = c;
				`BBX_CC_NE: cond_true = ~z;
				`BBX_CC_EQ: cond_true = z;
				`BBX_CC_VC: cond_true = ~v;
				`BBX_CC_VS: cond_true = v;
				`BBX_CC_PL: cond_true = ~n;
				`BBX_CC_MI: cond_true = n;
				`BBX_CC_GE: cond_true = ~(n ^ v);
				`BBX_CC_LT: cond_true = n ^ v;
				`BBX_CC_GT: cond_true = ~(z | (n ^ v));
				default:    cond_true = z | (n ^ v);
			endcase
		end
	endfunction

	wire [3:0]  op_field  = instr_word[`BBX_OPF_HI:`BBX_OPF_LO];
	wire [3:0]  sub_field = instr_word[`BBX_SUB_HI:`BBX_SUB_LO];
	wire [2:0]  bit_no    = instr_word[`BBX_BITNO_HI:`BBX_BITNO_LO];
	wire [3:0]  mode      = instr_word[`BBX_MODE_HI:`BBX_MODE_LO];
	wire        sel_exr   = instr_word[`BBX_SEL_EXR];
	wire        issue     = issue_valid & issue_ready;
	wire        cur_c     = condition_code_reg_q[`BBX_FLAG_C];
	wire        op_bit    = operand_byte[bit_no];
	wire [23:0] seq_pc    = pc_q + instr_len;
	wire [23:0] rel_pc    = seq_pc + {{8{ext_word[15]}}, ext_word[15:0]};
	wire [7:0]  ctl_cur   = sel_exr ? extended_control_reg_q : condition_code_reg_q;
	wire [15:0] move_cnt  = instr_word[`BBX_WORD_FORM] ? block_count_word_reg
	                                                   : {8'h00, block_count_word_reg[7:0]};
	wire [RP_W-1:0] ret_top = ret_ptr_q - {{(RP_W-1){1'b0}}, 1'b1};
	wire        wake_seen = wake_s2_q & wake_s3_q;

	assign issue_ready = (state_q == ST_IDLE);
	assign mem_req     = (state_q == ST_MV_RD) | (state_q == ST_MV_WR) |
	                     (state_q == ST_LDC_RD) | (state_q == ST_STC_WR);

	// The wake pin is asynchronous; only the agreeing second and third stages are used.
	always @(posedge clk) begin
		if (!nrst) begin
			wake_s1_q <= 1'b0;
			wake_s2_q <= 1'b0;
			wake_s3_q <= 1'b0;
		end else begin
			wake_s1_q <= wake_pin;
			wake_s2_q <= wake_s1_q;
			wake_s3_q <= wake_s2_q;
		end
	end

	// The return stack wraps when full, so deep recursion silently loses the oldest entry.
	always @(posedge clk) begin
		if (issue && (op_field == `BBX_OP_BSR || op_field == `BBX_OP_JSR)) begin
			ret_stack[ret_ptr_q] <= seq_pc;
		end
	end

	always @(posedge clk) begin
		if (!nrst) begin
			state_q                <= ST_IDLE;
			pc_q                   <= 24'h000000;
			condition_code_reg_q   <= `BBX_CCR_RST;
			extended_control_reg_q <= `BBX_EXR_RST;
			result_byte_q          <= 8'h00;
			result_we_q            <= 1'b0;
			blk_src_q              <= 24'h000000;
			blk_dst_q              <= 24'h000000;
			blk_cnt_q              <= 16'h0000;
			blk_done_q             <= 1'b0;
			sleeping_q             <= 1'b0;
			mem_we_q               <= 1'b0;
			mem_word_q             <= 1'b0;
			mem_addr_q             <= 24'h000000;
			mem_wdata_q            <= 16'h0000;
			ret_ptr_q              <= {RP_W{1'b0}};
			exc_pc_q               <= 24'h000000;
			exc_ccr_q              <= 8'h00;
			next_pc_q              <= 24'h000000;
			ldc_exr_q              <= 1'b0;
			move_byte_q            <= 8'h00;
		end else begin
			result_we_q <= 1'b0;
			blk_done_q  <= 1'b0;
			case (state_q)
				ST_IDLE: begin
					if (issue) begin
						pc_q <= seq_pc;
						case (op_field)
							`BBX_OP_NOP: begin
								pc_q <= pc_q + `BBX_INSTR_BYTES;
							end
							`BBX_OP_BITOP: begin
								case (sub_field)
									`BBX_BIT_XOR:
										condition_code_reg_q[`BBX_FLAG_C] <= cur_c ^ op_bit;
									`BBX_BIT_IXOR:
										condition_code_reg_q[`BBX_FLAG_C] <= cur_c ^ ~op_bit;
									`BBX_BIT_LD:
										condition_code_reg_q[`BBX_FLAG_C] <= op_bit;
									`BBX_BIT_ILD:
										condition_code_reg_q[`BBX_FLAG_C] <= ~op_bit;
									`BBX_BIT_ST: begin
										result_byte_q         <= operand_byte;
										result_byte_q[bit_no] <= cur_c;
										result_we_q           <= 1'b1;
									end
									`BBX_BIT_IST: begin
										result_byte_q         <= operand_byte;
										result_byte_q[bit_no] <= ~cur_c;
										result_we_q           <= 1'b1;
									end
									default: begin
									end
								endcase
							end
							`BBX_OP_BCC: begin
								if (cond_true(sub_field, condition_code_reg_q)) begin
									pc_q <= rel_pc;
								end else begin
									pc_q <= seq_pc;
								end
							end
							`BBX_OP_JMP: begin
								pc_q <= ext_word[23:0];
							end
							`BBX_OP_BSR: begin
								pc_q      <= rel_pc;
								ret_ptr_q <= ret_ptr_q + {{(RP_W-1){1'b0}}, 1'b1};
							end
							`BBX_OP_JSR: begin
								pc_q      <= ext_word[23:0];
								ret_ptr_q <= ret_ptr_q + {{(RP_W-1){1'b0}}, 1'b1};
							end
							`BBX_OP_RTS: begin
								pc_q      <= ret_stack[ret_top];
								ret_ptr_q <= ret_top;
							end
							`BBX_OP_TRAP: begin
								exc_pc_q  <= seq_pc;
								exc_ccr_q <= condition_code_reg_q;
								condition_code_reg_q[`BBX_FLAG_I] <= 1'b1;
								pc_q <= `BBX_TRAP_VEC_BASE + {19'h00000, bit_no[1:0], 3'h0};
							end
							`BBX_OP_RTE: begin
								pc_q                 <= exc_pc_q;
								condition_code_reg_q <= exc_ccr_q;
							end
							`BBX_OP_SLEEP: begin
								sleeping_q <= 1'b1;
								state_q    <= ST_SLEEP;
							end
							`BBX_OP_LDC: begin
								if (mode == `BBX_SRC_MEM) begin
									ldc_exr_q  <= sel_exr;
									mem_addr_q <= ext_word[23:0];
									mem_we_q   <= 1'b0;
									mem_word_q <= 1'b1;
									state_q    <= ST_LDC_RD;
								end else if (sel_exr) begin
									extended_control_reg_q <= (mode == `BBX_SRC_REG) ?
										operand_byte : ext_word[7:0];
								end else begin
									condition_code_reg_q <= (mode == `BBX_SRC_REG) ?
										operand_byte : ext_word[7:0];
								end
							end
							`BBX_OP_STC: begin
								if (mode == `BBX_SRC_MEM) begin
									mem_addr_q  <= ext_word[23:0];
									mem_we_q    <= 1'b1;
									mem_word_q  <= 1'b1;
									mem_wdata_q <= {ctl_cur, 8'h00};
									state_q     <= ST_STC_WR;
								end else begin
									result_byte_q <= ctl_cur;
									result_we_q   <= 1'b1;
								end
							end
							`BBX_OP_LOGC: begin
								if (sel_exr) begin
									case (sub_field)
										`BBX_LOG_AND: extended_control_reg_q <= ctl_cur & ext_word[7:0];
										`BBX_LOG_OR:  extended_control_reg_q <= ctl_cur | ext_word[7:0];
										`BBX_LOG_XOR: extended_control_reg_q <= ctl_cur ^ ext_word[7:0];
										default:      extended_control_reg_q <= ctl_cur;
									endcase
								end else begin
									case (sub_field)
										`BBX_LOG_AND: condition_code_reg_q <= ctl_cur & ext_word[7:0];
										`BBX_LOG_OR:  condition_code_reg_q <= ctl_cur | ext_word[7:0];
										`BBX_LOG_XOR: condition_code_reg_q <= ctl_cur ^ ext_word[7:0];
										default:      condition_code_reg_q <= ctl_cur;
									endcase
								end
							end
							`BBX_OP_MOVE: begin
								blk_src_q <= block_source_pointer;
								blk_dst_q <= block_dest_pointer;
								blk_cnt_q <= move_cnt;
								if (move_cnt == 16'h0000) begin
									blk_done_q <= 1'b1;
								end else begin
									pc_q       <= pc_q;
									next_pc_q  <= seq_pc;
									mem_addr_q <= block_source_pointer;
									mem_we_q   <= 1'b0;
									mem_word_q <= 1'b0;
									state_q    <= ST_MV_RD;
								end
							end
							default: begin
							end
						endcase
					end
				end
				ST_MV_RD: begin
					if (mem_ack) begin
						move_byte_q <= mem_rdata[7:0];
						blk_src_q   <= blk_src_q + 24'h000001;
						mem_addr_q  <= blk_dst_q;
						mem_we_q    <= 1'b1;
						mem_wdata_q <= {8'h00, mem_rdata[7:0]};
						state_q     <= ST_MV_WR;
					end
				end
				ST_MV_WR: begin
					if (mem_ack) begin
						blk_dst_q <= blk_dst_q + 24'h000001;
						blk_cnt_q <= blk_cnt_q - 16'h0001;
						mem_we_q  <= 1'b0;
						if (blk_cnt_q == 16'h0001) begin
							pc_q       <= next_pc_q;
							blk_done_q <= 1'b1;
							state_q    <= ST_IDLE;
						end else begin
							mem_addr_q <= blk_src_q;
							state_q    <= ST_MV_RD;
						end
					end
				end
				ST_LDC_RD: begin
					if (mem_ack) begin
						if (ldc_exr_q) begin
							extended_control_reg_q <= mem_rdata[15:8];
						end else begin
							condition_code_reg_q <= mem_rdata[15:8];
						end
						state_q <= ST_IDLE;
					end
				end
				ST_STC_WR: begin
					if (mem_ack) begin
						mem_we_q <= 1'b0;
						state_q  <= ST_IDLE;
					end
				end
				ST_SLEEP: begin
					// Waking needs a stable pin level, so short glitches do not end power-down.
					if (wake_seen) begin
						sleeping_q <= 1'b0;
						state_q    <= ST_IDLE;
					end
				end
				default: begin
					state_q <= ST_IDLE;
				end
			endcase
		end
	end

endmodule

// *** sim/bbx_mem_model.sv ***
// Byte memory answering the execution unit's bus, with optional wait states.
`timescale 1ns/1ps
module bbx_mem_model (
	input  wire        clk,
	input  wire        slow,
	input  wire        mem_req,
	input  wire        mem_we_q,
	input  wire        mem_word_q,
	input  wire [23:0] mem_addr_q,
	input  wire [15:0] mem_wdata_q,
	output reg         mem_ack,
	output reg  [15:0] mem_rdata
);
	reg  [7:0] mem [0:255];
	reg  [1:0] wait_q = 2'h0;
	wire [7:0] a = mem_addr_q[7:0];
	initial mem_ack = 1'b0;
	initial mem_rdata = 16'h0000;
	// Idle read data toggles so a late sample never sees the old value.
	always @(posedge clk) begin
		mem_ack <= 1'b0;
		mem_rdata <= ~mem_rdata;
		if (mem_req && !mem_ack && wait_q == (slow ? 2'h3 : 2'h0)) begin
			mem_ack <= 1'b1;
			wait_q <= 2'h0;
			mem_rdata <= mem_word_q ? {mem[a], mem[a + 8'h01]} : {~mem[a], mem[a]};
		end else if (mem_req && !mem_ack) begin
			wait_q <= wait_q + 2'h1;
		end
		if (mem_req && mem_ack && mem_we_q) begin
			mem[a] <= mem_word_q ? mem_wdata_q[15:8] : mem_wdata_q[7:0];
			if (mem_word_q) begin
				mem[a + 8'h01] <= mem_wdata_q[7:0];
			end
		end
	end
endmodule

// *** sim/bbx_props.sv ***
// Port-level checks for the execution unit.
`timescale 1ns/1ps
`include "bbx_defs.vh"
module bbx_props (
	input wire        clk,
	input wire        nrst,
	input wire        issue_valid,
	input wire        issue_ready,
	input wire [15:0] instr_word,
	input wire [31:0] ext_word,
	input wire [23:0] instr_len,
	input wire [7:0]  operand_byte,
	input wire [15:0] block_count_word_reg,
	input wire [23:0] pc_q,
	input wire [7:0]  condition_code_reg_q,
	input wire [7:0]  result_byte_q,
	input wire        result_we_q,
	input wire        blk_done_q,
	input wire        sleeping_q,
	input wire        mem_req,
	input wire        mem_ack,
	input wire [23:0] mem_addr_q
);
	wire [7:0] f   = condition_code_reg_q;
	wire [3:0] sub = instr_word[11:8];
	wire [2:0] bn  = instr_word[6:4];
	wire       x   = operand_byte[bn];
	wire [3:0] op  = (issue_valid && issue_ready) ? instr_word[15:12] : 4'hF;
	wire [7:0] t   = {f[2] | (f[3] ^ f[1]), f[3] ^ f[1], f[3], f[1], f[2], f[0], f[0] | f[2], 1'b0};
	wire       tk  = ~(t[sub[3:1]] ^ sub[0]);
	wire [15:0] cnt = instr_word[8] ? block_count_word_reg : {8'h00, block_count_word_reg[7:0]};
	default clocking @(posedge clk);
	endclocking
	default disable iff (!nrst);
	a_nop_step: assert property (op == `BBX_OP_NOP |=>
		pc_q == $past(pc_q) + 24'h000002 && $stable(f)) else $error("nop step wrong");
	a_branch_target: assert property (op == `BBX_OP_BCC |=> $stable(f) && pc_q ==
		$past(pc_q + instr_len + (tk ? {{8{ext_word[15]}}, ext_word[15:0]} : 24'h000000)))
		else $error("branch target wrong");
	a_xor_carry: assert property (op == `BBX_OP_BITOP && sub[3:1] == 3'h0 |=>
		f[0] == $past(f[0] ^ x ^ sub[0]) && f[7:1] == $past(f[7:1])) else $error("xor carry wrong");
	a_load_carry: assert property (op == `BBX_OP_BITOP && sub[3:1] == 3'h1 |=>
		f[0] == $past(x ^ sub[0])) else $error("bit load wrong");
	a_store_bit: assert property (op == `BBX_OP_BITOP && sub[3:1] == 3'h2 |=> result_we_q &&
		result_byte_q == $past(operand_byte & ~(8'h01 << bn) | ({7'h00, f[0] ^ sub[0]} << bn)))
		else $error("bit store wrong");
	a_move_start: assert property (op == `BBX_OP_MOVE |=>
		($past(cnt == 16'h0000) ? blk_done_q && issue_ready : mem_req && !blk_done_q))
		else $error("move start wrong");
	a_bus_hold: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr_q))
		else $error("bus request moved");
	a_done_ready: assert property (blk_done_q |-> issue_ready && !mem_req)
		else $error("move end not ready");
	a_sleep_busy: assert property (sleeping_q |-> !issue_ready) else $error("ready asleep");
	cover property (op == `BBX_OP_BCC && tk);
	cover property (blk_done_q);
	cover property (sleeping_q ##1 !sleeping_q);
endmodule
bind bbx_exec bbx_props u_props (.clk, .nrst, .issue_valid, .issue_ready, .instr_word,
	.ext_word, .instr_len, .operand_byte, .pc_q, .condition_code_reg_q, .result_byte_q,
	.result_we_q, .blk_done_q, .sleeping_q, .mem_req, .mem_ack, .mem_addr_q, .block_count_word_reg);

// *** sim/testbench.sv ***
// Directed bench for the execution unit with a memory partner.
`timescale 1ns/1ps
`include "bbx_defs.vh"
module testbench;
	reg         clk = 1'b0;
	reg         nrst = 1'b0;
	reg         issue_valid = 1'b0;
	reg  [15:0] instr_word = 16'h0000;
	reg  [31:0] ext_word = 32'h00000000;
	reg  [23:0] instr_len = 24'h000002;
	reg  [7:0]  operand_byte = 8'h00;
	reg  [23:0] block_source_pointer = 24'h000080;
	reg  [23:0] block_dest_pointer = 24'h0000A0;
	reg  [15:0] block_count_word_reg = 16'h0103;
	reg         wake_pin = 1'b0;
	reg         slow = 1'b0;
	wire        issue_ready, result_we_q, blk_done_q, sleeping_q, mem_req, mem_we_q, mem_word_q, mem_ack;
	wire [23:0] pc_q, blk_src_q, blk_dst_q, mem_addr_q;
	wire [7:0]  condition_code_reg_q, extended_control_reg_q, result_byte_q;
	wire [15:0] mem_wdata_q, mem_rdata, blk_cnt_q;
	integer     mismatches = 0;
	integer     tests_run = 0;
	integer     cycles = 0;
	integer     i, j, k;
	reg  [23:0] pc0;
	reg         c, x;
	bbx_exec u_dut (.clk, .nrst, .issue_valid, .issue_ready, .instr_word, .ext_word, .instr_len,
		.operand_byte, .block_source_pointer, .block_dest_pointer, .block_count_word_reg,
		.wake_pin, .pc_q, .condition_code_reg_q, .extended_control_reg_q, .result_byte_q,
		.result_we_q, .blk_src_q, .blk_dst_q, .blk_cnt_q, .blk_done_q, .sleeping_q,
		.mem_req, .mem_we_q, .mem_word_q, .mem_addr_q, .mem_wdata_q, .mem_ack, .mem_rdata);
	bbx_mem_model u_mem (.clk, .slow, .mem_req, .mem_we_q, .mem_word_q, .mem_addr_q,
		.mem_wdata_q, .mem_ack, .mem_rdata);
	always #2.5 clk = ~clk;
	task report_and_stop;
		begin
			$display("comparisons %0d mismatches %0d", tests_run, mismatches);
			if (mismatches == 0 && tests_run > 0) begin
				$display("All checks passed");
			end else begin
				$display("Checks failed");
			end
			$finish;
		end
	endtask
	// A hung handshake would otherwise stall the run forever.
	always @(posedge clk) begin
		cycles = cycles + 1;
		if (cycles == 30000) begin
			mismatches = mismatches + 1;
			report_and_stop;
		end
	end
	// Wide enough for a flag packed beside a full program counter or register.
	task check(input [31:0] got, input [31:0] exp);
		begin
			tests_run = tests_run + 1;
			if (got !== exp) begin
				mismatches = mismatches + 1;
				$display("mismatch at %0t got %h expected %h", $time, got, exp);
			end
		end
	endtask
	task issue(input [15:0] w, input [31:0] e, input [23:0] n, input [7:0] b);
		begin
			@(negedge clk);
			instr_word = w;
			ext_word = e;
			instr_len = n;
			operand_byte = b;
			issue_valid = 1'b1;
			@(negedge clk);
			issue_valid = 1'b0;
			for (k = 0; k < 200 && !issue_ready; k = k + 1) begin
				@(negedge clk);
			end
		end
	endtask
	task setf(input s, input [7:0] v);
		issue({`BBX_OP_LDC, 4'h0, s, 3'h0, `BBX_SRC_IMM}, {24'h000000, v}, 24'h000002, 8'h00);
	endtask
	function taken(input [3:0] cc, input [3:0] f);
		reg [7:0] t;
		begin
			t = {f[2] | (f[3] ^ f[1]), f[3] ^ f[1], f[3], f[1], f[2], f[0], f[0] | f[2], 1'b0};
			taken = ~(t[cc[3:1]] ^ cc[0]);
		end
	endfunction
	initial begin
		for (i = 0; i < 3; i = i + 1) begin
			u_mem.mem[8'h80 + i] = 8'h11 * (i + 1);
		end
		u_mem.mem[8'hA3] = 8'hFF;
		repeat (12) @(negedge clk);
		nrst = 1'b1;
		check(pc_q, 24'h000000);
		check(condition_code_reg_q, 8'h80);
		check(extended_control_reg_q, 8'h07);
		issue({`BBX_OP_NOP, 12'h000}, 32'h0, 24'h000004, 8'h00);
		check(pc_q, 24'h000002);
		for (i = 0; i < 6; i = i + 1) begin
			for (j = 0; j < 4; j = j + 1) begin
				c = j[0];
				x = j[1];
				setf(1'b0, {7'h00, c});
				issue({`BBX_OP_BITOP, i[3:0], 2'h0, j[1], ~j[1], `BBX_SRC_REG}, 32'h0, 24'h2, 8'hA5);
				case (i)
					0: check(condition_code_reg_q[0], c ^ x);
					1: check(condition_code_reg_q[0], c ^ !x);
					2: check(condition_code_reg_q[0], x);
					3: check(condition_code_reg_q[0], !x);
					default: check({result_we_q, result_byte_q},
						{1'b1, j[1] ? {5'h14, c ^ i[0], 2'h1} : {6'h29, c ^ i[0], 1'b1}});
				endcase
			end
		end
		for (i = 0; i < 6; i = i + 1) begin
			setf(i[0], 8'h5A);
			issue({`BBX_OP_LOGC, 2'h0, i[2:1], i[0], 7'h00}, 32'h3C, 24'h2, 8'h00);
			check(i[0] ? extended_control_reg_q : condition_code_reg_q,
				i < 2 ? 8'h18 : (i < 4 ? 8'h7E : 8'h66));
		end
		$display("bit and logic tests done");
		for (i = 0; i < 16; i = i + 1) begin
			for (j = 0; j < 16; j = j + 1) begin
				setf(1'b0, j[7:0]);
				pc0 = taken(i[3:0], j[3:0]) ? pc_q - 24'h00000C : pc_q + 24'h000004;
				issue({`BBX_OP_BCC, i[3:0], 8'h00}, 32'h0000FFF0, 24'h000004, 8'h00);
				check(pc_q, pc0);
				check(condition_code_reg_q, j[7:0]);
			end
		end
		issue({`BBX_OP_JMP, 12'h000}, 32'h00001234, 24'h000004, 8'h00);
		check(pc_q, 24'h001234);
		issue({`BBX_OP_BSR, 12'h000}, 32'h00000100, 24'h000004, 8'h00);
		check(pc_q, 24'h001338);
		issue({`BBX_OP_JSR, 12'h000}, 32'h00002000, 24'h000004, 8'h00);
		check(pc_q, 24'h002000);
		issue({`BBX_OP_RTS, 12'h000}, 32'h0, 24'h000002, 8'h00);
		check(pc_q, 24'h00133C);
		issue({`BBX_OP_RTS, 12'h000}, 32'h0, 24'h000002, 8'h00);
		check(pc_q, 24'h001238);
		setf(1'b0, 8'h05);
		pc0 = pc_q;
		issue({`BBX_OP_TRAP, 12'h010}, 32'h0, 24'h000002, 8'h00);
		check({pc_q, condition_code_reg_q[7]}, {24'h000028, 1'b1});
		issue({`BBX_OP_RTE, 12'h000}, 32'h0, 24'h000002, 8'h00);
		check({pc_q, condition_code_reg_q}, {pc0 + 24'h000002, 8'h05});
		$display("branch tests done");
		issue({`BBX_OP_STC, 4'h0, 1'b1, 3'h0, `BBX_SRC_REG}, 32'h0, 24'h000002, 8'h00);
		check(result_byte_q, 8'h66);
		issue({`BBX_OP_LDC, 4'h0, 1'b1, 3'h0, `BBX_SRC_REG}, 32'h0, 24'h000002, 8'h3C);
		check(extended_control_reg_q, 8'h3C);
		slow = 1'b1;
		setf(1'b0, 8'hC3);
		issue({`BBX_OP_STC, 4'h0, 1'b0, 3'h0, `BBX_SRC_MEM}, 32'h40, 24'h000004, 8'h00);
		check({u_mem.mem[8'h40], u_mem.mem[8'h41]}, 16'hC300);
		issue({`BBX_OP_LDC, 4'h0, 1'b1, 3'h0, `BBX_SRC_MEM}, 32'h40, 24'h000004, 8'h00);
		check(extended_control_reg_q, 8'hC3);
		pc0 = pc_q;
		issue({`BBX_OP_MOVE, 12'h000}, 32'h0, 24'h000004, 8'h00);
		check({blk_done_q, pc_q}, {1'b1, pc0 + 24'h000004});
		check(blk_src_q, 24'h000083);
		check(blk_dst_q, 24'h0000A3);
		check(blk_cnt_q, 16'h0000);
		for (i = 0; i < 4; i = i + 1) begin
			check(u_mem.mem[8'hA0 + i], i < 3 ? 8'h11 * (i + 1) : 8'hFF);
		end
		block_count_word_reg = 16'h0000;
		pc0 = pc_q;
		issue({`BBX_OP_MOVE, 12'h100}, 32'h0, 24'h000004, 8'h00);
		check({blk_done_q, pc_q}, {1'b1, pc0 + 24'h000004});
		$display("memory tests done");
		issue({`BBX_OP_SLEEP, 12'h000}, 32'h0, 24'h000002, 8'h00);
		check({sleeping_q, issue_ready}, 2'h2);
		wake_pin = 1'b1;
		for (i = 0; i < 10 && sleeping_q; i = i + 1) begin
			@(negedge clk);
		end
		check(sleeping_q, 1'b0);
		$display("sleep test done");
		report_and_stop;
	end
endmodule
